// file: logic/msac_ctrl.sv
// Control of a 16-input multiplexed 8-bit successive approximation converter.
//
// Overview of operation
// - Latch the 4-bit channel select on the rising edge of the latch strobe.
// - With the gate pin high and the software gate bit set, close the switch whose index equals the select.
// - With the gate low, open every channel switch whatever the select.
// - Start rising edge clears conversion registers; they stay clear while high.
// - After start falls, wait for next cycle boundary, drop end flag, convert.
// - Eight clocks per step, eight steps, sixty-four clocks per conversion.
// - Each step presents a ladder tap, compares, updates the bit-trial register.
// - When all steps end, copy the bit-trial register into the output register.
// - Raise the end flag again once the result sits in the output register.
// - Drive result pins only while output enable is high, else float.
// - Old result stays readable until one clock before the next completion.
`timescale 1ns/1ns
`default_nettype none
`include "msac_regs.svh"

module msac_ctrl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire msac_pkg::msac_wb_req_s wb_req_i,
  output msac_pkg::msac_wb_rsp_s wb_rsp_o,
  input wire logic [3:0] chan_addr_i,
  input wire logic addr_latch_i,
  input wire logic start_i,
  input wire logic channel_gate_i,
  input wire logic out_enable_i,
  input wire logic comp_i,
  output logic [15:0] switch_o,
  output logic [7:0] tap_o,
  output logic eoc_o,
  output logic [7:0] data_o,
  output logic data_oe_o
);
  import msac_pkg::*;

  // Sequencer and approximation state.
  msac_state_e state_reg;
  logic [2:0] phase_reg;
  logic [2:0] bit_reg;
  logic [7:0] bit_trial_register;
  logic [7:0] trial_next;
  logic [7:0] result_reg;
  logic eoc_reg;
  logic data_oe_reg;

  // Software side.
  logic [1:0] ctrl_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic wb_req;
  logic wr_ctrl;

  // Combined control levels and edges.
  logic start_level;
  logic start_rise;
  logic latch_rise;
  logic gate_level;
  logic [3:0] chan_latched;
  logic step_end;
  logic last_step;

  // Software may start a conversion as well as the start pin; the two are
  // simply ORed, so either one held high keeps the registers cleared.
  assign start_level = start_i | ctrl_reg[`MSAC_CTRL_START_BIT];

  // Software may force the multiplexer off, never on, when the pin is low.
  assign gate_level = channel_gate_i & ctrl_reg[`MSAC_CTRL_GATE_BIT];

  // Edge detectors for the start level and the address latch strobe.
  msac_edge u_start_edge (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .level_i(start_level),
    .rise_o(start_rise)
  );

  msac_edge u_latch_edge (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .level_i(addr_latch_i),
    .rise_o(latch_rise)
  );

  // Channel select register and analog switch drive.
  msac_chan_sel u_chan_sel (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(latch_rise),
    .addr_i(chan_addr_i),
    .gate_i(gate_level),
    .chan_o(chan_latched),
    .switch_o(switch_o)
  );

  // Free-running step phase. The approximation cycle keeps running even when
  // idle, which is why a new conversion waits for the next boundary.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_reg <= `MSAC_FIRST_PHASE;
    end else begin
      phase_reg <= phase_reg + 3'h1;
    end
  end

  assign step_end = (phase_reg == `MSAC_LAST_PHASE);
  assign last_step = (bit_reg == `MSAC_LOW_BIT);

  // Outcome of the current step: a comparator high means the tap lies above
  // the input, so the trial bit is dropped; the next lower bit is then tried.
  always_comb begin
    trial_next = bit_trial_register;
    if (comp_i) begin
      trial_next[bit_reg] = 1'b0;
    end
    if (!last_step) begin
      trial_next[bit_reg - 3'h1] = 1'b1;
    end
  end

  // Conversion sequencer. A start edge wins over every other state, so a
  // restart in the middle of a conversion abandons it cleanly.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= MSAC_IDLE;
    end else if (start_rise) begin
      state_reg <= MSAC_CLEAR;
    end else begin
      unique case (state_reg)
        MSAC_IDLE: begin
          state_reg <= MSAC_IDLE;
        end
        MSAC_CLEAR: begin
          if (!start_level) begin
            state_reg <= MSAC_WAIT;
          end
        end
        MSAC_WAIT: begin
          if (step_end) begin
            state_reg <= MSAC_CONV;
          end
        end
        MSAC_CONV: begin
          if (step_end && last_step) begin
            state_reg <= MSAC_IDLE;
          end
        end
      endcase
    end
  end

  // Bit-trial register and bit index. Held clear while start is high.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bit_trial_register <= 8'h00;
      bit_reg <= `MSAC_TOP_BIT;
    end else if (start_rise || state_reg == MSAC_CLEAR) begin
      bit_trial_register <= 8'h00;
      bit_reg <= `MSAC_TOP_BIT;
    end else if (state_reg == MSAC_WAIT && step_end) begin
      bit_trial_register <= `MSAC_TRIAL_TOP;
      bit_reg <= `MSAC_TOP_BIT;
    end else if (state_reg == MSAC_CONV && step_end) begin
      bit_trial_register <= trial_next;
      if (!last_step) begin
        bit_reg <= bit_reg - 3'h1;
      end
    end
  end

  // Output register. It only changes in the final clock of a conversion,
  // so the previous answer stays valid until then.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_reg <= `MSAC_RESULT_RESET;
    end else if (!start_rise && state_reg == MSAC_CONV && step_end
      && last_step) begin
      // A restart in the final clock abandons the run, so nothing is stored.
      result_reg <= trial_next;
    end
  end

  // End-of-conversion flag: low from the first step, high the clock after
  // the result has been stored. A restart keeps it as is until the next
  // cycle boundary actually begins converting.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      eoc_reg <= 1'b1;
    end else if (start_rise) begin
      eoc_reg <= eoc_reg;
    end else if (state_reg == MSAC_WAIT && step_end) begin
      eoc_reg <= 1'b0;
    end else if (state_reg == MSAC_IDLE && !eoc_reg) begin
      eoc_reg <= 1'b1;
    end
  end

  // Output pin enable follows the enable input one clock later; the data
  // lines always carry the output register and float by the enable alone.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_oe_reg <= 1'b0;
    end else begin
      data_oe_reg <= out_enable_i;
    end
  end

  // The ladder tap follows the bit-trial register directly.
  assign tap_o = bit_trial_register;
  assign eoc_o = eoc_reg;
  assign data_o = result_reg;
  assign data_oe_o = data_oe_reg;

  // Wishbone slave: a request is answered one clock after it is seen and the
  // acknowledge is dropped in the following clock, so each access takes two
  // clocks and a request still held after its acknowledge is answered again.
  assign wb_req = wb_req_i.cyc & wb_req_i.stb & ~ack_reg;
  assign wr_ctrl = wb_req & wb_req_i.we & wb_req_i.sel[0]
    & (wb_req_i.adr == `MSAC_OFF_CONTROL);

  // Control register write; only the low byte lane carries fields.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= `MSAC_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= wb_req_i.dat[1:0];
    end
  end

  // Read data mux; unmapped offsets read zero and are still acknowledged.
  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (wb_req_i.adr)
      `MSAC_OFF_CONTROL: begin
        rdata_next[1:0] = ctrl_reg;
      end
      `MSAC_OFF_STATUS: begin
        rdata_next[`MSAC_ST_EOC_BIT] = eoc_reg;
        rdata_next[`MSAC_ST_BUSY_BIT] = (state_reg != MSAC_IDLE);
        rdata_next[`MSAC_ST_CHAN_MSB:`MSAC_ST_CHAN_LSB] = chan_latched;
      end
      `MSAC_OFF_RESULT: begin
        rdata_next[7:0] = result_reg;
      end
      default: begin
        rdata_next = 32'h0000_0000;
      end
    endcase
  end

  // Acknowledge and read data registers.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= wb_req;
      if (wb_req) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  assign wb_rsp_o.ack = ack_reg;
  assign wb_rsp_o.dat = rdata_reg;

endmodule

`default_nettype wire

// file: logic/msac_regs.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef MSAC_REGS_SVH
`define MSAC_REGS_SVH

`define MSAC_CLK_PERIOD_NS 100
`define MSAC_STEP_CLOCKS 8
`define MSAC_RESULT_BITS 8
`define MSAC_CONV_CLOCKS (`MSAC_STEP_CLOCKS * `MSAC_RESULT_BITS)
`define MSAC_LAST_PHASE 3'h7
`define MSAC_FIRST_PHASE 3'h0
`define MSAC_TOP_BIT 3'h7
`define MSAC_LOW_BIT 3'h0
`define MSAC_TRIAL_TOP 8'h80
`define MSAC_CHAN_COUNT 16

`define MSAC_OFF_CONTROL 4'h0
`define MSAC_OFF_STATUS 4'h4
`define MSAC_OFF_RESULT 4'h8

`define MSAC_CTRL_START_BIT 0
`define MSAC_CTRL_GATE_BIT 1
`define MSAC_CTRL_RESET 2'h2
`define MSAC_ST_EOC_BIT 0
`define MSAC_ST_BUSY_BIT 1
`define MSAC_ST_CHAN_LSB 2
`define MSAC_ST_CHAN_MSB 5
`define MSAC_RESULT_RESET 8'h00

`endif

// file: logic/msac_pkg.sv
// Types shared by the converter control block and its parts.
`default_nettype none
package msac_pkg;

  // Classic Wishbone request from the master.
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } msac_wb_req_s;

  // Classic Wishbone answer from this slave.
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } msac_wb_rsp_s;

  // Sequencer states of the approximation control.
  typedef enum logic [1:0] {
    MSAC_IDLE,
    MSAC_CLEAR,
    MSAC_WAIT,
    MSAC_CONV
  } msac_state_e;

endpackage

`default_nettype wire

// file: logic/msac_edge.sv
// Rising edge detector for a synchronous input strobe.
`timescale 1ns/1ns
`default_nettype none

module msac_edge (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic level_i,
  output logic rise_o
);

  logic prev_reg;

  // Previous level, cleared at reset so a strobe already high counts once.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= level_i;
    end
  end

  // A pulse in the cycle where the level is first seen high.
  assign rise_o = level_i & ~prev_reg;

endmodule

`default_nettype wire

// file: logic/msac_chan_sel.sv
// Channel select register and switch decoder of the input multiplexer.
`timescale 1ns/1ns
`default_nettype none

module msac_chan_sel (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic [3:0] addr_i,
  input wire logic gate_i,
  output logic [3:0] chan_o,
  output logic [15:0] switch_o
);

  logic [3:0] chan_reg;
  logic [15:0] switch_reg;

  // The select value is captured only on the latch strobe edge.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chan_reg <= 4'h0;
    end else if (load_i) begin
      chan_reg <= addr_i;
    end
  end

  // One switch closed per latched index; all open while gated off.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      switch_reg <= 16'h0000;
    end else if (gate_i) begin
      switch_reg <= 16'h0001 << chan_reg;
    end else begin
      switch_reg <= 16'h0000;
    end
  end

  assign chan_o = chan_reg;
  assign switch_o = switch_reg;

endmodule

`default_nettype wire

// file: verification/msac_ctrl_properties.sv
// Port checker of the converter control block.
`timescale 1ns/1ns
`default_nettype none
module msac_ctrl_properties (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire msac_pkg::msac_wb_req_s wb_req_i,
  input wire msac_pkg::msac_wb_rsp_s wb_rsp_o,
  input wire logic [3:0] chan_addr_i,
  input wire logic addr_latch_i,
  input wire logic start_i,
  input wire logic channel_gate_i,
  input wire logic out_enable_i,
  input wire logic [15:0] switch_o,
  input wire logic [7:0] tap_o,
  input wire logic eoc_o,
  input wire logic [7:0] data_o,
  input wire logic data_oe_o
);
  import msac_pkg::*;
  logic [7:0] low_cnt;
  logic abort_seen;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Length of the low flag; a restart while low makes the run longer.
  always_ff @(posedge clk_i) begin
    low_cnt <= (rst_i || eoc_o) ? 8'h00 : low_cnt + 8'h01;
    abort_seen <= !rst_i && !eoc_o && (abort_seen || start_i);
  end
  sequence conv_begin;
    $fell(eoc_o);
  endsequence
  sequence conv_end;
    $rose(eoc_o) ##0 !abort_seen;
  endsequence
  ack_single_a: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
    else $error("ack longer than one cycle");
  ack_next_a: assert property (wb_req_i.cyc && wb_req_i.stb &&
    !wb_rsp_o.ack |=> wb_rsp_o.ack) else $error("request not answered");
  tap_first_a: assert property (conv_begin |-> tap_o == 8'h80)
    else $error("first tap wrong");
  start_low_a: assert property (conv_begin |-> !$past(start_i))
    else $error("conversion began with start high");
  start_wait_a: assert property ($fell(start_i) |-> ##[0:11] !eoc_o)
    else $error("conversion did not begin");
  // Sixty-four clocks of conversion, plus the clock in which the stored
  // result settles before the flag rises again.
  conv_length_a: assert property (conv_end |-> low_cnt == 8'h41)
    else $error("conversion length wrong");
  result_hold_a: assert property (eoc_o && $past(eoc_o) &&
    !$past(rst_i) |-> $stable(data_o)) else $error("result changed");
  oe_follow_a: assert property (!$past(rst_i) |->
    data_oe_o == $past(out_enable_i)) else $error("drive enable wrong");
  gate_off_a: assert property (!channel_gate_i [*3] |-> !switch_o)
    else $error("switch closed while gated");
  one_switch_a: assert property ($onehot0(switch_o))
    else $error("several switches closed");
  latch_route_a: assert property ($rose(addr_latch_i) && channel_gate_i
    |-> ##[1:3] switch_o == 16'h0001 << chan_addr_i)
    else $error("latched channel not routed");
endmodule
bind msac_ctrl msac_ctrl_properties u_props (.clk_i(clk_i), .rst_i(rst_i),
  .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o), .chan_addr_i(chan_addr_i),
  .addr_latch_i(addr_latch_i), .start_i(start_i),
  .channel_gate_i(channel_gate_i), .out_enable_i(out_enable_i),
  .switch_o(switch_o), .tap_o(tap_o), .eoc_o(eoc_o), .data_o(data_o),
  .data_oe_o(data_oe_o));
`default_nettype wire

// file: verification/msac_comp_model.sv
// Comparator and external multiplexer facing the converter control.
`timescale 1ns/1ns
`default_nettype none
module msac_comp_model (
  input wire logic [15:0] switch_i,
  input wire logic [7:0] tap_i,
  output logic comp_o
);
  logic [7:0] level;
  // Input n carries n over its inverse; with all switches open the
  // external multiplexer shows 8'hA5, the level of input 10, so a leaky switch on any other input shows up.
  always_comb begin
    level = 8'hA5;
    for (int n = 0; n < 16; n++) begin
      if (switch_i[n]) begin
        level = {n[3:0], ~n[3:0]};
      end
    end
    comp_o = tap_i > level;
  end
endmodule
`default_nettype wire

// file: verification/msac_ctrl_tb_top.sv
// Self-checking bench of the converter control block.
`timescale 1ns/1ns
`default_nettype none
module msac_ctrl_tb_top;
  import msac_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  msac_wb_req_s wb_req_i = '0;
  msac_wb_rsp_s wb_rsp_o;
  logic [3:0] chan_addr_i = 4'h0;
  logic addr_latch_i = 1'b0;
  logic start_i = 1'b0;
  logic channel_gate_i = 1'b1;
  logic out_enable_i = 1'b0;
  logic comp_i;
  logic [15:0] switch_o;
  logic [7:0] tap_o;
  logic eoc_o;
  logic [7:0] data_o;
  logic data_oe_o;
  logic [31:0] rd;
  int errors = 0;
  int comparisons = 0;
  msac_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
    .wb_rsp_o(wb_rsp_o), .chan_addr_i(chan_addr_i),
    .addr_latch_i(addr_latch_i), .start_i(start_i),
    .channel_gate_i(channel_gate_i), .out_enable_i(out_enable_i),
    .comp_i(comp_i), .switch_o(switch_o), .tap_o(tap_o), .eoc_o(eoc_o),
    .data_o(data_o), .data_oe_o(data_oe_o));
  msac_comp_model far (.switch_i(switch_o), .tap_i(tap_o), .comp_o(comp_i));
  // Clock of 100 ns.
  always #50 clk_i = ~clk_i;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    if (errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // One classic cycle; the request stands until ack is sampled.
  task automatic wb(input logic we, input logic [3:0] adr,
    input logic [31:0] wd);
    @(posedge clk_i);
    wb_req_i <= '{1'b1, 1'b1, we, adr, 4'hF, wd};
    @(posedge clk_i);
    while (wb_rsp_o.ack !== 1'b1) @(posedge clk_i);
    rd = wb_rsp_o.dat;
    wb_req_i <= '0;
  endtask
  task automatic rd_chk(input logic [3:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0);
    chk(rd, exp);
  endtask
  // Start by pin, or by the control register with the gate denied.
  task automatic pulse(input bit sw);
    if (sw) begin
      wb(1'b1, 4'h0, 32'h1);
      wb(1'b1, 4'h0, 32'h0);
    end else begin
      @(posedge clk_i);
      start_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      start_i <= 1'b0;
    end
  endtask
  task automatic conv(input bit abrt, input bit sw, input logic [7:0] exp);
    pulse(sw);
    for (int i = 0; i < 20 && eoc_o !== 1'b0; i++) @(posedge clk_i);
    chk(eoc_o, 1'b0);
    // Status while converting: flag low and sequencer busy.
    wb(1'b0, 4'h4, 32'h0);
    chk(rd[1:0], 2'h2);
    if (abrt) begin
      repeat (10) @(posedge clk_i);
      pulse(1'b0);
    end
    for (int i = 0; i < 200 && eoc_o !== 1'b1; i++) @(posedge clk_i);
    chk(eoc_o, 1'b1);
    chk(data_o, exp);
  endtask
  // Hang guard; the tests take about 1700 cycles.
  initial begin
    #2000000;
    errors++;
    end_of_test();
  end
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(4'h0, 32'h2);
    rd_chk(4'h4, 32'h1);
    rd_chk(4'h8, 32'h0);
    rd_chk(4'hC, 32'h0);
    for (int c = 0; c < 16; c++) begin
      @(posedge clk_i);
      chan_addr_i <= c[3:0];
      @(posedge clk_i);
      addr_latch_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      addr_latch_i <= 1'b0;
      conv(c == 7, 1'b0, {c[3:0], ~c[3:0]});
      rd_chk(4'h4, {26'h0, c[3:0], 2'h1});
      wb(1'b1, 4'h8, 32'hFF);
      rd_chk(4'h8, {24'h0, c[3:0], ~c[3:0]});
    end
    channel_gate_i <= 1'b0;
    conv(1'b0, 1'b0, 8'hA5);
    channel_gate_i <= 1'b1;
    conv(1'b0, 1'b1, 8'hA5);
    wb(1'b1, 4'h0, 32'h2);
    conv(1'b0, 1'b0, 8'hF0);
    out_enable_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk(data_oe_o, 1'b1);
    out_enable_i <= 1'b0;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chk(data_oe_o, 1'b0);
    rd_chk(4'h8, 32'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
